// File: design/eie_regs.svh
// Register offsets, field positions and reset values for the enable register
`ifndef EIE_REGS_SVH
`define EIE_REGS_SVH

// Special-function address of the enable register, visible on every page
`define EIE_ENABLE_ONE_ADDR    8'hE6
// Reset value of the enable register
`define EIE_ENABLE_ONE_RESET   8'h00
// Field positions
`define EIE_LIN_BIT            3'h7
`define EIE_TIMER3_BIT         3'h6
`define EIE_CMP1_BIT           3'h5
`define EIE_CMP0_BIT           3'h4
`define EIE_PCA_BIT            3'h3
`define EIE_ADC_DONE_BIT       3'h2
`define EIE_ADC_WIN_BIT        3'h1
`define EIE_SMBUS_BIT          3'h0

`endif

// File: design/eie_pkg.sv
// Types shared by the extended interrupt enable block
package eie_pkg;
   // One bit per gated source, index equals the enable bit position
   typedef logic [7:0] eie_vec_t;
   // State of the register write port
   typedef enum logic [0:0] {EIE_IDLE, EIE_WRITTEN} eie_wr_e;
endpackage

// File: design/eie_src_merge.sv
// Merges the raw peripheral flags into one request per enable bit
`timescale 1ns/10ps
`include "eie_regs.svh"
module eie_src_merge
   import eie_pkg::*;
(
   input  wire logic     lin_irq_flag,
   input  wire logic     timer_three_low_overflow,
   input  wire logic     timer_three_high_overflow,
   input  wire logic     comparator_one_rise_flag,
   input  wire logic     comparator_one_fall_flag,
   input  wire logic     comparator_zero_rise_flag,
   input  wire logic     comparator_zero_fall_flag,
   input  wire logic     pca_irq_flag,
   input  wire logic     adc_conversion_done_flag,
   input  wire logic     adc_window_hit_flag,
   input  wire logic     smbus_irq_flag,
   output eie_vec_t      src_vec
);
   // Pure combinational merge; flags are never altered here, only observed
   always_comb begin
      src_vec                    = 8'h00;
      src_vec[`EIE_LIN_BIT]      = lin_irq_flag;
      src_vec[`EIE_TIMER3_BIT]   = timer_three_low_overflow | timer_three_high_overflow;
      src_vec[`EIE_CMP1_BIT]     = comparator_one_rise_flag | comparator_one_fall_flag;
      src_vec[`EIE_CMP0_BIT]     = comparator_zero_rise_flag | comparator_zero_fall_flag;
      src_vec[`EIE_PCA_BIT]      = pca_irq_flag;
      src_vec[`EIE_ADC_DONE_BIT] = adc_conversion_done_flag;
      src_vec[`EIE_ADC_WIN_BIT]  = adc_window_hit_flag;
      src_vec[`EIE_SMBUS_BIT]    = smbus_irq_flag;
   end
endmodule

// File: design/eie_enable_one.sv
// Extended interrupt enable register one and its request gating
//
// Overview of operation
// - Bit 7 gates LIN controller requests
// - Bit 6 gates timer 3 overflow requests
// - Bit 5 gates comparator 1 edge requests
// - Bit 4 gates comparator 0 edge requests
// - Bit 3 gates counter array requests
// - Bit 2 gates ADC conversion-done request
// - Bit 1 gates ADC window-compare request
// - Bit 0 gates SMBus requests
// - Register at 0xE6, all pages, read/write
`timescale 1ns/10ps
`include "eie_regs.svh"
module eie_enable_one
   import eie_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Special-function register port from the core
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_rvalid,
   // Peripheral request flags
   input  wire logic       lin_irq_flag,
   input  wire logic       timer_three_low_overflow,
   input  wire logic       timer_three_high_overflow,
   input  wire logic       comparator_one_rise_flag,
   input  wire logic       comparator_one_fall_flag,
   input  wire logic       comparator_zero_rise_flag,
   input  wire logic       comparator_zero_fall_flag,
   input  wire logic       pca_irq_flag,
   input  wire logic       adc_conversion_done_flag,
   input  wire logic       adc_window_hit_flag,
   input  wire logic       smbus_irq_flag,
   // Gated requests toward interrupt arbitration, one per source
   output logic            lin_irq_req,
   output logic            timer_three_irq_req,
   output logic            comparator_one_irq_req,
   output logic            comparator_zero_irq_req,
   output logic            counter_array_irq_req,
   output logic            adc_done_irq_req,
   output logic            adc_window_irq_req,
   output logic            smbus_irq_req,
   // Live copy of the enable bits for the core
   output logic      [7:0] extended_interrupt_enable_one
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   eie_vec_t enable_reg;     // Enable bits, software owned
   eie_vec_t src_vec;        // Merged source flags
   eie_vec_t req_next;       // Gated requests before the output flops
   eie_vec_t req_reg;        // Registered requests
   eie_wr_e  wr_state_reg;   // Tracks the write port for observability
   logic     hit;            // Address decode for the register

   // Address match; the register ignores page selection entirely
   function automatic logic eie_addr_hit(input logic [7:0] a);
      return a == `EIE_ENABLE_ONE_ADDR;
   endfunction

   assign hit = eie_addr_hit(sfr_addr);

   ////////////////////////////////////////////////////////////////////////////
   // Source merge
   eie_src_merge u_merge (
      .lin_irq_flag              (lin_irq_flag),
      .timer_three_low_overflow  (timer_three_low_overflow),
      .timer_three_high_overflow (timer_three_high_overflow),
      .comparator_one_rise_flag  (comparator_one_rise_flag),
      .comparator_one_fall_flag  (comparator_one_fall_flag),
      .comparator_zero_rise_flag (comparator_zero_rise_flag),
      .comparator_zero_fall_flag (comparator_zero_fall_flag),
      .pca_irq_flag              (pca_irq_flag),
      .adc_conversion_done_flag  (adc_conversion_done_flag),
      .adc_window_hit_flag       (adc_window_hit_flag),
      .smbus_irq_flag            (smbus_irq_flag),
      .src_vec                   (src_vec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Enable register write
   // All eight bits are writable; a write takes effect on the next edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         enable_reg <= `EIE_ENABLE_ONE_RESET;
      end else if (sfr_wr && hit) begin
         enable_reg <= sfr_wdata;
      end
   end

   // Write tracker, mainly for debug visibility of the port
   // It marks the edge just after a taken write, so the assertions can tie
   // the mirror to the byte that was written one edge before.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_state_reg <= EIE_IDLE;
      end else begin
         // Stays marked while writes come back to back
         case (wr_state_reg)
            EIE_IDLE:    wr_state_reg <= (sfr_wr && hit) ? EIE_WRITTEN : EIE_IDLE;
            EIE_WRITTEN: wr_state_reg <= (sfr_wr && hit) ? EIE_WRITTEN : EIE_IDLE;
            default:     wr_state_reg <= EIE_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port
   // Read data is registered, so it lands one cycle after the strobe.
   // Other addresses read zero so this block can be OR-ed onto a shared bus.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sfr_rdata  <= 8'h00;
         sfr_rvalid <= 1'b0;
      end else begin
         sfr_rvalid <= sfr_rd && hit;
         sfr_rdata  <= (sfr_rd && hit) ? enable_reg : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request gating
   // Flags are only read, never written, so a flag held while masked
   // raises its request one edge after the enable is set.
   // Comparator flags stay high until their owner clears them, so the
   // request also stays high; no local latch is needed.
   always_comb begin
      req_next = src_vec & enable_reg;
   end

   // Output flops, one cycle behind flag and enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_reg <= 8'h00;
      end else begin
         req_reg <= req_next;
      end
   end

   // Enable mirror
   // Kept as its own flop so the core sees the enables without going
   // through the read port; costs eight flops, saves a read cycle.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         extended_interrupt_enable_one <= `EIE_ENABLE_ONE_RESET;
      end else if (sfr_wr && hit) begin
         extended_interrupt_enable_one <= sfr_wdata;
      end
   end

   // Each request pin comes straight from its flop, no logic after it
   assign lin_irq_req             = req_reg[`EIE_LIN_BIT];
   assign timer_three_irq_req     = req_reg[`EIE_TIMER3_BIT];
   assign comparator_one_irq_req  = req_reg[`EIE_CMP1_BIT];
   assign comparator_zero_irq_req = req_reg[`EIE_CMP0_BIT];
   assign counter_array_irq_req   = req_reg[`EIE_PCA_BIT];
   assign adc_done_irq_req        = req_reg[`EIE_ADC_DONE_BIT];
   assign adc_window_irq_req      = req_reg[`EIE_ADC_WIN_BIT];
   assign smbus_irq_req           = req_reg[`EIE_SMBUS_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   // Each request must equal its merged flags AND its enable bit one edge
   // earlier; equality rather than implication catches a stuck request too.
   lin_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      lin_irq_req == $past(lin_irq_flag & enable_reg[`EIE_LIN_BIT]))
      else $error("LIN request does not follow flag and enable");
   timer_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      timer_three_irq_req == $past(enable_reg[`EIE_TIMER3_BIT]
         & (timer_three_low_overflow | timer_three_high_overflow)))
      else $error("Timer 3 request mismatch");
   cmp_one_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      comparator_one_irq_req == $past(enable_reg[`EIE_CMP1_BIT]
         & (comparator_one_rise_flag | comparator_one_fall_flag)))
      else $error("Comparator 1 request mismatch");
   cmp_zero_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      comparator_zero_irq_req == $past(enable_reg[`EIE_CMP0_BIT]
         & (comparator_zero_rise_flag | comparator_zero_fall_flag)))
      else $error("Comparator 0 request mismatch");
   pca_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      counter_array_irq_req == $past(pca_irq_flag & enable_reg[`EIE_PCA_BIT]))
      else $error("Counter array request mismatch");
   adc_done_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      adc_done_irq_req == $past(adc_conversion_done_flag & enable_reg[`EIE_ADC_DONE_BIT]))
      else $error("ADC done request mismatch");
   adc_win_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      adc_window_irq_req == $past(adc_window_hit_flag & enable_reg[`EIE_ADC_WIN_BIT]))
      else $error("ADC window request mismatch");
   smbus_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      smbus_irq_req == $past(smbus_irq_flag & enable_reg[`EIE_SMBUS_BIT]))
      else $error("SMBus request mismatch");

   // With every enable cleared, no request may leave the block
   masked_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(enable_reg) == 8'h00 |-> req_reg == 8'h00)
      else $error("Request raised while all sources are masked");
   // An SMBus flag held while masked must fire once its enable is set
   pending_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (smbus_irq_flag && !enable_reg[`EIE_SMBUS_BIT]
         ##1 smbus_irq_flag && enable_reg[`EIE_SMBUS_BIT])
      |=> smbus_irq_req)
      else $error("Pending flag did not fire on enable");

   // A write followed at once by a read returns the written byte
   reg_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (sfr_wr && sfr_addr == `EIE_ENABLE_ONE_ADDR
         ##1 sfr_rd && sfr_addr == `EIE_ENABLE_ONE_ADDR && !sfr_wr)
      |=> sfr_rvalid && sfr_rdata == $past(sfr_wdata, 2))
      else $error("Readback differs from written value");
   // Without a taken read the read bus stays at zero, so it can be OR-ed
   read_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(sfr_rd && hit) |-> !sfr_rvalid && sfr_rdata == 8'h00)
      else $error("Read data driven without a read of the register");
   // A taken read answers on the next edge with the register contents
   read_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(sfr_rd && hit) |-> sfr_rvalid && sfr_rdata == $past(enable_reg))
      else $error("Read answer missing or wrong");
   // After a marked write the mirror holds the byte that was written
   write_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_state_reg == EIE_WRITTEN |-> extended_interrupt_enable_one == $past(sfr_wdata))
      else $error("Enable mirror does not hold the written byte");

endmodule

// File: verif/eie_src_model.sv
// Behavioural model of the peripheral flag sources that feed the enable block
`timescale 1ns/10ps
module eie_src_model (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [10:0] set_vec,
   input  wire logic [10:0] clr_vec,
   output logic      [10:0] flags
);
   // Flags are sticky: software owns them, so only a clear or a reset drops them
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flags <= 11'h000;
      end else begin
         flags <= (flags | set_vec) & ~clr_vec;
      end
   end
endmodule

// File: verif/eie_enable_one_bench.sv
// Self-checking bench for the extended interrupt enable register one
`timescale 1ns/10ps
module eie_enable_one_bench;
   import eie_pkg::*;
   typedef struct {logic [10:0] f; logic [7:0] en; logic [7:0] q;} eie_row_s;
   logic        mclk, rst_n, sfr_wr, sfr_rd, sfr_rvalid;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, mirror, rd_d;
   logic [10:0] set_vec, clr_vec, fl;
   wire  [7:0]  req;
   logic        rd_v;
   int          n_errors, comparisons;
   // Flag order: lin, t3 low, t3 high, c1 rise, c1 fall, c0 rise, c0 fall, pca, adc, win, smb
   eie_row_s rows [15] = '{'{11'h400,8'h80,8'h80}, '{11'h400,8'h7F,8'h00},
      '{11'h200,8'h40,8'h40}, '{11'h100,8'h40,8'h40}, '{11'h080,8'h20,8'h20},
      '{11'h040,8'hDF,8'h00}, '{11'h020,8'h10,8'h10}, '{11'h010,8'h10,8'h10},
      '{11'h008,8'h08,8'h08}, '{11'h004,8'h04,8'h04}, '{11'h002,8'h02,8'h02},
      '{11'h001,8'h01,8'h01}, '{11'h7FF,8'hFF,8'hFF}, '{11'h7FF,8'h00,8'h00},
      '{11'h7FF,8'hA5,8'hA5}};
   eie_src_model i_src (.mclk(mclk), .rst_n(rst_n), .set_vec(set_vec), .clr_vec(clr_vec),
      .flags(fl));
   eie_enable_one i_dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
      .lin_irq_flag(fl[10]), .timer_three_low_overflow(fl[9]),
      .timer_three_high_overflow(fl[8]), .comparator_one_rise_flag(fl[7]),
      .comparator_one_fall_flag(fl[6]), .comparator_zero_rise_flag(fl[5]),
      .comparator_zero_fall_flag(fl[4]), .pca_irq_flag(fl[3]),
      .adc_conversion_done_flag(fl[2]), .adc_window_hit_flag(fl[1]), .smbus_irq_flag(fl[0]),
      .lin_irq_req(req[7]), .timer_three_irq_req(req[6]), .comparator_one_irq_req(req[5]),
      .comparator_zero_irq_req(req[4]), .counter_array_irq_req(req[3]),
      .adc_done_irq_req(req[2]), .adc_window_irq_req(req[1]), .smbus_irq_req(req[0]),
      .extended_interrupt_enable_one(mirror));
   // Free-running system clock, 10 ns period
   always #5 mclk = ~mclk;
   // Compare one value and count it
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Let n rising edges pass, then settle
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // One write strobe, taken at the following edge
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge mclk);
      sfr_wr    <= 1'b0;
   endtask
   // One read strobe; data and valid stand for the cycle after it
   task automatic sfr_read(input logic [7:0] a);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge mclk);
      sfr_rd   <= 1'b0;
      #1;
      rd_d = sfr_rdata;
      rd_v = sfr_rvalid;
   endtask
   // Pulse the flag set or clear lines for one cycle
   task automatic flags_pulse(input logic [10:0] s, input logic [10:0] c);
      @(posedge mclk);
      set_vec <= s;
      clr_vec <= c;
      @(posedge mclk);
      set_vec <= 11'h000;
      clr_vec <= 11'h000;
   endtask
   // Verdict and end of run
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Guard against a hung run
   initial begin
      #200000;
      n_errors++;
      complete_run();
   end
   initial begin
      mclk = 0; rst_n = 0; sfr_wr = 0; sfr_rd = 0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
      set_vec = 11'h000; clr_vec = 11'h000; n_errors = 0; comparisons = 0;
      tick(2);
      rst_n <= 1'b1;
      check({8'h00, mirror}, 16'h0000);
      sfr_read(8'hE6);
      check({7'h00, rd_v, rd_d}, 16'h0100);
      $display("test reset done");
      // Table rows: program the mask, raise the flags, look at the requests
      foreach (rows[i]) begin
         flags_pulse(11'h000, 11'h7FF);
         sfr_write(8'hE6, rows[i].en);
         flags_pulse(rows[i].f, 11'h000);
         tick(2);
         check({mirror, req}, {rows[i].en, rows[i].q});
      end
      $display("test table done");
      // Unmapped address: write ignored, read gives nothing
      sfr_write(8'hE7, 8'h00);
      sfr_read(8'hE7);
      check({7'h00, rd_v, rd_d, mirror}, 24'h0000A5);
      // Read in the same cycle as a write returns the old value
      @(posedge mclk);
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {2'b11, 8'hE6, 8'h5A};
      @(posedge mclk);
      {sfr_wr, sfr_rd} <= 2'b00;
      #1;
      check({7'h00, sfr_rvalid, sfr_rdata}, 16'h01A5);
      sfr_read(8'hE6);
      check({7'h00, rd_v, rd_d}, 16'h015A);
      // Write, then read on the very next edge: the new byte comes back
      @(posedge mclk);
      {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, 8'hE6, 8'h3C};
      @(posedge mclk);
      {sfr_wr, sfr_rd} <= 2'b01;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      check({7'h00, sfr_rvalid, sfr_rdata}, 16'h013C);
      $display("test register port done");
      // Pending masked flags fire once enabled and stay set throughout
      sfr_write(8'hE6, 8'h00);
      flags_pulse(11'h7FF, 11'h7FF);
      flags_pulse(11'h021, 11'h000);
      tick(2);
      check({5'h00, fl, req}, {5'h00, 11'h021, 8'h00});
      sfr_write(8'hE6, 8'h11);
      tick(2);
      check({5'h00, fl, req}, {5'h00, 11'h021, 8'h11});
      $display("test pending flags done");
      // Reset in mid-run clears the register and the requests
      @(posedge mclk);
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      check({mirror, req}, 16'h0000);
      // The block works again after the mid-run reset
      sfr_write(8'hE6, 8'h01);
      flags_pulse(11'h001, 11'h000);
      tick(2);
      check({mirror, req}, 16'h0101);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
